// [verilog/input_function_decoder.sv]
// servo input function decoder: limits, gain set select, control mode select
// assumes contacts are asynchronous pins (high = closed), motion requests and
// the apb master run on pclk
//
// What this block does
// - setting 1 or 4: a is cw limit, b is ccw, active closed.
// - setting 2 or 5: same assignment, each active while contact open.
// - active limit blocks only its direction and raises its warning.
// - settings 3,6,13,16 leave both inputs general purpose; 3 at reset.
// - setting 7/8: only a as cw limit, closed/open active.
// - setting 9/10: only b as ccw limit, closed/open active.
// - setting 11: b is cw, a is ccw, active closed.
// - setting 12: b is cw, a is ccw, active open.
// - setting 17/18: only b as cw limit, closed/open active.
// - setting 19/20: only a as ccw limit, closed/open active.
// - gain code is the rightmost digit of the multi setting.
// - gain code 1: closed picks gain set one, open set two.
// - gain code 2: closed picks gain set two, open set one.
// - gain code 3 default: always gain set one.
// - control mode code is the third digit from the right.
// - mode code 1: closed picks mode one, open mode two.
// - inverted mode code: closed picks mode two, open mode one.
// - mode code 3 default: switching off, input ignored.
//
// Chosen here: the register offsets and the APB slave port.
`timescale 1ns/100ps
`include "input_decoder_map.svh"

module input_function_decoder
    import input_decoder_pkg::*;
(
    // clock and reset
    input wire logic pclk,
    input wire logic presetn,
    // apb slave
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [7:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    // contact pins, high = closed
    input wire logic limit_input_a,
    input wire logic limit_input_b,
    input wire logic gain_select_input,
    input wire logic mode_select_input,
    // motion requests from the motion core
    input wire logic cw_move_req,
    input wire logic ccw_move_req,
    // decoded results
    output logic cw_move_en,
    output logic ccw_move_en,
    output logic cw_limit_warning,
    output logic ccw_limit_warning,
    output logic gain_two_sel,
    output logic control_mode_two_sel
);

    // ----------------------------------------
    // input synchronisers
    // ----------------------------------------
    contacts_t pins;
    contacts_t meta_q;
    contacts_t sync_q;

    assign pins = '{mode_sel: mode_select_input, gain_sel: gain_select_input,
                    lim_b: limit_input_b, lim_a: limit_input_a};

    // first stage feeds only the second stage
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            meta_q <= '0;
            sync_q <= '0;
        end else begin
            meta_q <= pins;
            sync_q <= meta_q;
        end
    end

    // ----------------------------------------
    // apb registers
    // ----------------------------------------
    logic [`LIMIT_CFG_W-1:0] limit_cfg_q;
    logic [`MULTI_CFG_W-1:0] multi_cfg_q;
    logic setup_ph;
    logic wr_acc;
    logic hit;
    logic [31:0] rd_d;
    logic cw_limit_q;
    logic ccw_limit_q;

    assign setup_ph = psel && !penable;
    assign wr_acc = psel && penable && pwrite;

    // writes take effect on the access edge
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            limit_cfg_q <= `LIMIT_CFG_RST;
            multi_cfg_q <= `MULTI_CFG_RST;
        end else if (wr_acc) begin
            if (paddr == `LIMIT_CFG_OFS) begin
                limit_cfg_q <= pwdata[`LIMIT_CFG_W-1:0];
            end
            if (paddr == `MULTI_CFG_OFS) begin
                multi_cfg_q <= pwdata[`MULTI_CFG_W-1:0];
            end
        end
    end

    // read mux; status shows synced contacts and decoded state
    always_comb begin
        rd_d = 32'h0000_0000;
        hit = 1'b1;
        unique case (paddr)
            `LIMIT_CFG_OFS: rd_d[`LIMIT_CFG_W-1:0] = limit_cfg_q;
            `MULTI_CFG_OFS: rd_d[`MULTI_CFG_W-1:0] = multi_cfg_q;
            `STATUS_OFS: rd_d[7:0] = {gain_two_sel, control_mode_two_sel,
                                      ccw_limit_q, cw_limit_q, sync_q};
            default: hit = 1'b0;
        endcase
    end

    // answer is prepared in setup so the access phase needs no wait state
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            prdata <= 32'h0000_0000;
            pslverr <= 1'b0;
            pready <= 1'b0;
        end else begin
            pready <= 1'b1;
            if (setup_ph) begin
                prdata <= pwrite ? 32'h0000_0000 : rd_d;
                pslverr <= !hit;
            end
        end
    end

    // ----------------------------------------
    // limit assignment decode
    // ----------------------------------------
    limit_map_t lmap;

    // 13 and 16 appear twice; the general purpose reading is kept
    always_comb begin
        lmap = '0;
        unique case (limit_cfg_q)
            5'h01, 5'h04: lmap = '{1'b1, 1'b0, 1'b0, 1'b1, 1'b1, 1'b0};
            5'h02, 5'h05: lmap = '{1'b1, 1'b0, 1'b1, 1'b1, 1'b1, 1'b1};
            5'h07: lmap.cw_en = 1'b1;
            5'h08: lmap = '{1'b1, 1'b0, 1'b1, 1'b0, 1'b0, 1'b0};
            5'h09: lmap = '{1'b0, 1'b0, 1'b0, 1'b1, 1'b1, 1'b0};
            5'h0A: lmap = '{1'b0, 1'b0, 1'b0, 1'b1, 1'b1, 1'b1};
            5'h0B: lmap = '{1'b1, 1'b1, 1'b0, 1'b1, 1'b0, 1'b0};
            5'h0C: lmap = '{1'b1, 1'b1, 1'b1, 1'b1, 1'b0, 1'b1};
            5'h11: lmap = '{1'b1, 1'b1, 1'b0, 1'b0, 1'b0, 1'b0};
            5'h12: lmap = '{1'b1, 1'b1, 1'b1, 1'b0, 1'b0, 1'b0};
            5'h13: lmap.ccw_en = 1'b1;
            5'h14: lmap = '{1'b0, 1'b0, 1'b0, 1'b1, 1'b0, 1'b1};
            default: lmap = '0;
        endcase
    end

    // ----------------------------------------
    // limit and motion state
    // ----------------------------------------
    logic cw_lim_d;
    logic ccw_lim_d;
    logic cw_pin;
    logic ccw_pin;

    // a general purpose input is masked by a cleared enable
    assign cw_pin = lmap.cw_from_b ? sync_q.lim_b : sync_q.lim_a;
    assign ccw_pin = lmap.ccw_from_b ? sync_q.lim_b : sync_q.lim_a;
    assign cw_lim_d = lmap.cw_en && (cw_pin ^ lmap.cw_open);
    assign ccw_lim_d = lmap.ccw_en && (ccw_pin ^ lmap.ccw_open);

    // warnings follow the limit level, so they clear on their own
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            cw_limit_q <= 1'b0;
            ccw_limit_q <= 1'b0;
        end else begin
            cw_limit_q <= cw_lim_d;
            ccw_limit_q <= ccw_lim_d;
        end
    end

    assign cw_limit_warning = cw_limit_q;
    assign ccw_limit_warning = ccw_limit_q;

    // gating uses the same decoded limit, so warning and block line up
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            cw_move_en <= 1'b0;
            ccw_move_en <= 1'b0;
        end else begin
            cw_move_en <= cw_move_req && !cw_lim_d;
            ccw_move_en <= ccw_move_req && !ccw_lim_d;
        end
    end

    // ----------------------------------------
    // gain and control mode select
    // ----------------------------------------
    logic [3:0] gain_code;
    logic [3:0] mode_code;

    assign gain_code = multi_cfg_q[`GAIN_DIGIT_LSB +: 4];
    assign mode_code = multi_cfg_q[`MODE_DIGIT_LSB +: 4];

    // any code other than normal or invert leaves set one and mode one
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            gain_two_sel <= 1'b0;
        end else if (gain_code == `FN_NORMAL) begin
            gain_two_sel <= !sync_q.gain_sel;
        end else if (gain_code == `FN_INVERT) begin
            gain_two_sel <= sync_q.gain_sel;
        end else begin
            gain_two_sel <= 1'b0;
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            control_mode_two_sel <= 1'b0;
        end else if (mode_code == `FN_NORMAL) begin
            control_mode_two_sel <= !sync_q.mode_sel;
        end else if (mode_code == `FN_INVERT) begin
            control_mode_two_sel <= sync_q.mode_sel;
        end else begin
            control_mode_two_sel <= 1'b0;
        end
    end

    // ----------------------------------------
    // assertions
    // ----------------------------------------
    default clocking cb @(posedge pclk); endclocking
    default disable iff (!presetn);

    // synchroniser depth and bus answer; both need clean cycles out of reset
    a_sync_two_stage: assert property (
        $past(presetn, 2) && $past(presetn) |-> sync_q.lim_a == $past(pins.lim_a, 2))
        else $error("limit a not delayed by two stages");
    a_sync_mode_pin: assert property (
        $past(presetn, 2) && $past(presetn) |-> sync_q.mode_sel == $past(pins.mode_sel, 2))
        else $error("mode pin not delayed by two stages");
    a_no_wait: assert property (
        $past(presetn) |-> pready)
        else $error("pready low outside reset");
    a_unmapped_err: assert property (
        setup_ph && !(paddr inside {`LIMIT_CFG_OFS, `MULTI_CFG_OFS, `STATUS_OFS}) |=> pslverr)
        else $error("unmapped address gave no error");

    // limit decode, one check per setting; 6, 13 and 16 share one, 3 and 11 come later
    a_mode_one_closed: assert property (
        limit_cfg_q == 5'h01 && $stable(limit_cfg_q)
        |-> cw_limit_q == $past(sync_q.lim_a) && ccw_limit_q == $past(sync_q.lim_b))
        else $error("setting 1 limits wrong");
    a_mode_open: assert property (
        limit_cfg_q == 5'h05 && $stable(limit_cfg_q)
        |-> cw_limit_q == !$past(sync_q.lim_a))
        else $error("setting 5 cw limit wrong");
    a_mode_four: assert property (
        limit_cfg_q == 5'h04 && $stable(limit_cfg_q)
        |-> cw_limit_q == $past(sync_q.lim_a) && ccw_limit_q == $past(sync_q.lim_b))
        else $error("setting 4 limits wrong");
    a_open_ccw: assert property (
        limit_cfg_q == 5'h02 && $stable(limit_cfg_q)
        |-> ccw_limit_q == !$past(sync_q.lim_b))
        else $error("setting 2 ccw limit wrong");
    a_cw_only_a: assert property (
        limit_cfg_q == 5'h07 && $stable(limit_cfg_q)
        |-> cw_limit_q == $past(sync_q.lim_a) && !ccw_limit_q)
        else $error("setting 7 limits wrong");
    a_cw_only_open: assert property (
        limit_cfg_q == 5'h08 && $stable(limit_cfg_q)
        |-> cw_limit_q == !$past(sync_q.lim_a) && !ccw_limit_q)
        else $error("setting 8 limits wrong");
    a_ccw_only_b: assert property (
        limit_cfg_q == 5'h09 && $stable(limit_cfg_q)
        |-> ccw_limit_q == $past(sync_q.lim_b) && !cw_limit_q)
        else $error("setting 9 limits wrong");
    a_ccw_only_open: assert property (
        limit_cfg_q == 5'h0A && $stable(limit_cfg_q)
        |-> ccw_limit_q == !$past(sync_q.lim_b) && !cw_limit_q)
        else $error("setting 10 limits wrong");
    a_swap_open: assert property (
        limit_cfg_q == 5'h0C && $stable(limit_cfg_q)
        |-> cw_limit_q == !$past(sync_q.lim_b) && ccw_limit_q == !$past(sync_q.lim_a))
        else $error("setting 12 swap wrong");
    a_cw_from_b: assert property (
        limit_cfg_q == 5'h11 && $stable(limit_cfg_q)
        |-> cw_limit_q == $past(sync_q.lim_b) && !ccw_limit_q)
        else $error("setting 17 limits wrong");
    a_cw_b_open: assert property (
        limit_cfg_q == 5'h12 && $stable(limit_cfg_q)
        |-> cw_limit_q == !$past(sync_q.lim_b) && !ccw_limit_q)
        else $error("setting 18 limits wrong");
    a_ccw_from_a: assert property (
        limit_cfg_q == 5'h13 && $stable(limit_cfg_q)
        |-> ccw_limit_q == $past(sync_q.lim_a) && !cw_limit_q)
        else $error("setting 19 limits wrong");
    a_ccw_a_open: assert property (
        limit_cfg_q == 5'h14 && $stable(limit_cfg_q)
        |-> ccw_limit_q == !$past(sync_q.lim_a) && !cw_limit_q)
        else $error("setting 20 limits wrong");
    a_gp_others: assert property (
        (limit_cfg_q == 5'h06 || limit_cfg_q == 5'h0D || limit_cfg_q == 5'h10)
        && $stable(limit_cfg_q) |-> !cw_limit_q && !ccw_limit_q)
        else $error("general purpose setting raised a limit");

    // motion gating follows the same decoded limit as the warning
    a_block_cw: assert property (
        cw_limit_q |-> !cw_move_en)
        else $error("cw motion passed an active limit");
    a_ccw_free: assert property (
        !ccw_limit_q && $past(ccw_move_req) && $past(presetn) |-> ccw_move_en)
        else $error("ccw motion blocked without limit");
    a_block_ccw: assert property (
        ccw_limit_q |-> !ccw_move_en)
        else $error("ccw motion passed an active limit");
    a_cw_free: assert property (
        !cw_limit_q && $past(cw_move_req) && $past(presetn) |-> cw_move_en)
        else $error("cw motion blocked without limit");

    // reset default and plain swap
    a_gp_quiet: assert property (
        limit_cfg_q == 5'h03 && $stable(limit_cfg_q) |-> !cw_limit_q && !ccw_limit_q)
        else $error("general purpose input raised a limit");
    a_swap_closed: assert property (
        limit_cfg_q == 5'h0B && $stable(limit_cfg_q)
        |-> cw_limit_q == $past(sync_q.lim_b) && ccw_limit_q == $past(sync_q.lim_a))
        else $error("setting 11 swap wrong");

    // gain and mode select; each code comes from its own digit
    a_gain_normal: assert property (
        gain_code == 4'h1 && $stable(gain_code) |-> gain_two_sel == !$past(sync_q.gain_sel))
        else $error("gain code 1 select wrong");
    a_gain_fixed: assert property (
        gain_code == 4'h3 [*2] |-> !gain_two_sel)
        else $error("gain code 3 did not hold gain set one");
    a_mode_invert: assert property (
        mode_code == 4'h2 && $stable(mode_code)
        |-> control_mode_two_sel == $past(sync_q.mode_sel))
        else $error("inverted mode select wrong");
    a_gain_invert: assert property (
        gain_code == 4'h2 && $stable(gain_code)
        |-> gain_two_sel == $past(sync_q.gain_sel))
        else $error("gain code 2 select wrong");
    a_mode_normal: assert property (
        mode_code == 4'h1 && $stable(mode_code)
        |-> control_mode_two_sel == !$past(sync_q.mode_sel))
        else $error("mode code 1 select wrong");
    a_mode_fixed: assert property (
        mode_code == 4'h3 [*2] |-> !control_mode_two_sel)
        else $error("mode code 3 did not hold mode one");

    // warnings drop with their limit
    a_warn_clears: assert property (
        $fell(cw_lim_d) |=> !cw_limit_warning)
        else $error("cw warning did not clear");
    a_warn_ccw: assert property (
        $fell(ccw_lim_d) |=> !ccw_limit_warning)
        else $error("ccw warning did not clear");

    // main scenarios
    c_cw_limit_hit: cover property (cw_move_req ##1 cw_limit_q && !cw_move_en);
    c_swap_ccw: cover property (limit_cfg_q == 5'h0C && ccw_limit_q);
    c_gain_two: cover property (gain_code == 4'h2 && gain_two_sel);
    c_mode_two: cover property (mode_code == 4'h1 && control_mode_two_sel);
    c_cw_from_b: cover property (limit_cfg_q == 5'h11 && cw_limit_q);

endmodule

// [verilog/input_decoder_map.svh]
// offsets, field positions, reset values and codes of the input decoder
// assumes inclusion by bare name from the decoder module only
`ifndef INPUT_DECODER_MAP_SVH
`define INPUT_DECODER_MAP_SVH

// ----------------------------------------
// register byte offsets
// ----------------------------------------
`define LIMIT_CFG_OFS 8'h00
`define MULTI_CFG_OFS 8'h04
`define STATUS_OFS 8'h08

// ----------------------------------------
// field positions and reset values
// ----------------------------------------
`define LIMIT_CFG_W 5
`define LIMIT_CFG_RST 5'h03
`define MULTI_CFG_W 16
`define MULTI_CFG_RST 16'h3333
`define GAIN_DIGIT_LSB 0
`define MODE_DIGIT_LSB 8

// ----------------------------------------
// function codes of one digit
// ----------------------------------------
`define FN_NORMAL 4'h1
`define FN_INVERT 4'h2

`endif

// [verilog/input_decoder_pkg.sv]
// types shared by the input decoder and its bench
// assumes nothing beyond the map header
package input_decoder_pkg;

    // ----------------------------------------
    // decoded limit assignment
    // ----------------------------------------
    typedef struct packed {
        logic cw_en;
        logic cw_from_b;
        logic cw_open;
        logic ccw_en;
        logic ccw_from_b;
        logic ccw_open;
    } limit_map_t;

    // ----------------------------------------
    // four function inputs, high = contact closed
    // ----------------------------------------
    typedef struct packed {
        logic mode_sel;
        logic gain_sel;
        logic lim_b;
        logic lim_a;
    } contacts_t;

endpackage

// [verif/contact_model.sv]
// contact model: end-of-travel sensors and host switch contacts
// assumes the bench sets the wanted contact state just after a pclk edge
`timescale 1ns/100ps

module contact_model
    import input_decoder_pkg::*;
(
    // clock
    input wire logic pclk,
    // wanted contact state, high = closed
    input wire contacts_t closed,
    // contact pins
    output logic pin_a,
    output logic pin_b,
    output logic pin_gain,
    output logic pin_mode
);
    // contacts lag the command by one edge and change on that pclk edge, after the decoder has sampled them
    contacts_t state_q = '0;
    always @(posedge pclk) begin
        state_q <= closed;
    end
    assign pin_a = state_q.lim_a;
    assign pin_b = state_q.lim_b;
    assign pin_gain = state_q.gain_sel;
    assign pin_mode = state_q.mode_sel;
endmodule

// [verif/input_function_decoder_tb.sv]
// bench for the input function decoder: apb setup, contact patterns, checks
// assumes the decoder syncs pins in two flops; apb transfers wait on pready
`timescale 1ns/100ps

module input_function_decoder_tb;
    import input_decoder_pkg::*;
    logic pclk = 0, presetn = 0, psel = 0, penable = 0, pwrite = 0;
    logic [7:0] paddr = '0;
    logic [31:0] pwdata = '0, prdata, rd;
    logic pready, pslverr, er, a, b, g, m, cwr = 0, ccwr = 0;
    logic cwe, ccwe, cww, ccww, g2, m2;
    contacts_t cmd = '0;
    int errors = 0, total_checks = 0, cyc = 0, mc;
    logic [1:0] e;

    input_function_decoder dut (.pclk(pclk), .presetn(presetn), .psel(psel),
        .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
        .prdata(prdata), .pready(pready), .pslverr(pslverr), .limit_input_a(a),
        .limit_input_b(b), .gain_select_input(g), .mode_select_input(m),
        .cw_move_req(cwr), .ccw_move_req(ccwr), .cw_move_en(cwe), .ccw_move_en(ccwe),
        .cw_limit_warning(cww), .ccw_limit_warning(ccww), .gain_two_sel(g2),
        .control_mode_two_sel(m2));
    contact_model far (.pclk(pclk), .closed(cmd), .pin_a(a), .pin_b(b), .pin_gain(g),
        .pin_mode(m));

    // ----------------------------------------
    // clock, timeout and helpers
    // ----------------------------------------
    initial begin
        forever #5 pclk = ~pclk;
    end
    // a hung handshake would otherwise stall the run forever
    always @(posedge pclk) begin
        cyc++;
        if (cyc == 8000) begin
            errors++;
            results();
        end
    end
    task automatic tick(input int n);
        repeat (n) @(posedge pclk);
    endtask
    // one apb transfer, entered just after an edge; rd and er take the answer
    task automatic apb(input logic w, input logic [7:0] ad, input logic [31:0] d);
        psel <= 1;
        pwrite <= w;
        paddr <= ad;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1;
        do @(posedge pclk); while (pready !== 1'b1);
        rd = prdata;
        er = pslverr;
        psel <= 0;
        penable <= 0;
        // one idle edge, so a following call never re-raises psel in this step
        @(posedge pclk);
    endtask
    task automatic chk(input string n, input logic [31:0] x, input logic [31:0] y);
        total_checks++;
        if (y !== x) begin
            errors++;
            $display("[FAIL] %s expected %h seen %h", n, x, y);
        end
    endtask
    // expected {cw, ccw} limit state for a setting and contacts
    function automatic logic [1:0] lim(input int s, input logic x, input logic y);
        case (s)
            1, 4: return {x, y};
            2, 5: return {!x, !y};
            7: return {x, 1'b0};
            8: return {!x, 1'b0};
            9: return {1'b0, y};
            10: return {1'b0, !y};
            11: return {y, x};
            12: return {!y, !x};
            17: return {y, 1'b0};
            18: return {!y, 1'b0};
            19: return {1'b0, x};
            20: return {1'b0, !x};
            default: return 2'b00;
        endcase
    endfunction
    task automatic results();
        $display("checks %0d mismatches %0d", total_checks, errors);
        if (errors == 0 && total_checks > 0) $display("Testbench passed");
        else $display("Testbench failed");
        $finish;
    endtask

    // ----------------------------------------
    // test sequence
    // ----------------------------------------
    initial begin
        tick(20);
        presetn <= 1;
        tick(1);
        apb(0, 8'h00, 0);
        chk("limit_rst", 32'h03, rd);
        apb(0, 8'h04, 0);
        chk("multi_rst", 32'h3333, rd);
        apb(1, 8'h00, 32'hFFFFFFF4);
        apb(0, 8'h00, 0);
        chk("limit_rw", 32'h14, rd);
        apb(0, 8'h0C, 0);
        chk("unmapped", 32'h1, {31'h0, er});
        $display("test registers done");
        // every limit code from 0 to 20 against every contact pair
        for (int s = 0; s <= 20; s++) begin
            apb(1, 8'h00, s);
            for (int k = 0; k < 4; k++) begin
                cmd <= {2'b00, k[1], k[0]};
                ccwr <= !k[0];
                cwr <= 1;
                tick(6);
                e = lim(s, k[0], k[1]);
                chk("cw_warn", e[1], cww);
                chk("ccw_warn", e[0], ccww);
                chk("cw_en", !e[1], cwe);
                chk("ccw_en", !k[0] && !e[0], ccwe);
            end
        end
        $display("test limits done");
        // a pin change must not show before the synchroniser has passed it
        apb(1, 8'h00, 1);
        cmd <= '0;
        tick(6);
        cmd <= 4'b0001;
        tick(4);
        chk("sync_early", 0, cww);
        tick(1);
        chk("sync_late", 1, cww);
        apb(0, 8'h08, 0);
        chk("status", 32'h11, rd);
        $display("test sync done");
        for (int c = 1; c <= 3; c++) begin
            mc = c % 3 + 1;
            apb(1, 8'h04, {16'h0, 4'h3, mc[3:0], 4'h3, c[3:0]});
            for (int v = 0; v < 2; v++) begin
                cmd <= {v[0], v[0], 2'b00};
                tick(6);
                chk("gain", c == 3 ? 0 : (c == 1) != v[0], g2);
                chk("mode", mc == 3 ? 0 : (mc == 1) != v[0], m2);
            end
        end
        $display("test gain and mode done");
        results();
    end
endmodule
